// ===== dv/testbench.sv
/* self-checking bench for the paired timer: registers, prescale, gate, pin clock.
   assumes the checker and the pin model are compiled before it. */
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
   $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module testbench;
   logic        clk_i, ack, irq, adc, pin;
   logic        rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic        sleep = 1'b0, gate = 1'b0, go = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [3:0]  sel = 4'h3;
   logic [31:0] dat_w = 32'h0, dat_r, seed = 32'h9801;
   logic [7:0]  npulse = 8'h00;
   logic [15:0] q, p, h, l;
   int          n_errors = 0, tests_run = 0, cyc_cnt = 0, g, s;
   logic [9:0]  ix [10] = '{tpc_pkg::IDX_LO_CNT, tpc_pkg::IDX_HOLD, tpc_pkg::IDX_HI_CNT,
      tpc_pkg::IDX_LO_PR, tpc_pkg::IDX_HI_PR, tpc_pkg::IDX_LO_CTL, tpc_pkg::IDX_HI_CTL,
      tpc_pkg::IDX_IRQ_FLAG, tpc_pkg::IDX_IRQ_EN, 10'h000};
   logic [15:0] rv [10] = '{0, 0, 0, 16'hffff, 16'hffff, 0, 0, 0, 0, 0};
   logic [15:0] mk [10] = '{0, 0, 0, 0, 0, 16'ha07a, 16'ha072, 16'h0000, 16'h00c0, 0};
   tpc_timer i_tpc_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
      .wb_ack_o(ack), .gate_clock_input_pin_i(pin), .cpu_sleep_i(sleep),
      .cpu_idle_i(1'b0), .irq_o(irq), .adc_trigger_o(adc));
   tpc_pin_model i_tpc_pin_model (.gate_i(gate), .go_i(go), .pulses_i(npulse), .pin_o(pin));
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   function automatic int div_of(input int ps);
      return (ps == 0) ? 1 : (ps == 1) ? 8 : (ps == 2) ? 64 : 256;
   endfunction
   task automatic wb(input logic w, input logic [9:0] idx, input logic [15:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      dat_w <= {16'h0000, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      q = dat_r[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wait_adc();
      do @(posedge clk_i); while (adc !== 1'b1);
   endtask
   // cycles between two trigger pulses, with sleep held for s cycles between
   task automatic gap();
      time t0;
      wait_adc();
      t0 = $time;
      if (s > 0) begin
         @(posedge clk_i);
         sleep <= 1'b1;
         repeat (s) @(posedge clk_i);
         sleep <= 1'b0;
      end
      wait_adc();
      g = int'(($time - t0) / 10);
   endtask
   task automatic complete_run();
      $display("errors %0d, checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 60000) begin
         n_errors++;
         complete_run();
      end
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         wb(1'b0, ix[i], 16'h0000);
         `CHK(q, rv[i])
      end
      for (int i = 5; i < 10; i++) begin
         wb(1'b1, ix[i], 16'hffff);
         wb(1'b0, ix[i], 16'h0000);
         `CHK(q, mk[i])
         wb(1'b1, ix[i], 16'h0000);
      end
      for (int ps = 0; ps < 4; ps++) begin
         seed = xs(seed);
         p = 16'h0002 + seed[2:0];
         s = (ps == 0) ? 1 + int'(seed[9:7]) : 0;
         wb(1'b1, ix[5], 16'h0000);
         wb(1'b1, ix[3], p);
         wb(1'b1, ix[4], 16'h0000);
         wb(1'b1, ix[1], 16'h0000);
         wb(1'b1, ix[0], 16'h0000);
         wb(1'b1, ix[6], {10'h000, seed[5:4], 4'h0});
         wb(1'b1, ix[5], 16'h8008 | (16'(ps) << 4));
         gap();
         `CHK(g, (int'(p) + 1) * div_of(ps) + s)
      end
      wb(1'b1, ix[5], 16'h0000);
      wb(1'b1, ix[3], 16'hffff);
      wb(1'b1, ix[4], 16'hffff);
      wb(1'b1, ix[0], 16'h0000);
      wb(1'b1, ix[7], 16'h0000);
      wb(1'b1, ix[5], 16'h8048);
      seed = xs(seed);
      gate <= 1'b1;
      repeat (20 + seed[4:0]) @(posedge clk_i);
      gate <= 1'b0;
      repeat (8) @(posedge clk_i);
      wb(1'b0, ix[0], 16'h0000);
      `CHK(q, 16'd20 + seed[4:0])
      wb(1'b0, ix[7], 16'h0000);
      `CHK(q, 16'h0080)
      wb(1'b0, ix[0], 16'h0000);
      `CHK(q, 16'd20 + seed[4:0])
      wb(1'b1, ix[8], 16'h0080);
      repeat (2) @(posedge clk_i);
      `CHK(irq, 1'b1)
      wb(1'b1, ix[8], 16'h0000);
      repeat (2) @(posedge clk_i);
      `CHK(irq, 1'b0)
      wb(1'b1, ix[7], 16'h0000);
      wb(1'b0, ix[7], 16'h0000);
      `CHK(q, 16'h0000)
      wb(1'b1, ix[5], 16'h8030);
      repeat (100) @(posedge clk_i);
      wb(1'b1, ix[0], 16'h0000);
      repeat (200) @(posedge clk_i);
      wb(1'b0, ix[0], 16'h0000);
      `CHK(q, 16'h0000)
      repeat (60) @(posedge clk_i);
      wb(1'b0, ix[0], 16'h0000);
      `CHK(q, 16'h0001)
      wb(1'b1, ix[5], 16'h0000);
      seed = xs(seed);
      h = seed[15:0];
      l = seed[31:16];
      wb(1'b1, ix[2], 16'h0000);
      wb(1'b1, ix[1], h);
      wb(1'b1, ix[0], l);
      wb(1'b0, ix[2], 16'h0000);
      `CHK(q, 16'h0000)
      wb(1'b1, ix[5], 16'h0008);
      wb(1'b1, ix[1], h);
      wb(1'b1, ix[0], l);
      wb(1'b0, ix[2], 16'h0000);
      `CHK(q, h)
      wb(1'b1, ix[1], ~h);
      wb(1'b1, ix[5], 16'h0038);
      wb(1'b0, ix[0], 16'h0000);
      `CHK(q, l)
      wb(1'b0, ix[1], 16'h0000);
      `CHK(q, h)
      wb(1'b1, ix[1], 16'h0000);
      wb(1'b1, ix[0], 16'h0000);
      wb(1'b1, ix[5], 16'h800a);
      seed = xs(seed);
      npulse <= 8'd3 + seed[3:0];
      @(posedge clk_i);
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (100) @(posedge clk_i);
      wb(1'b0, ix[0], 16'h0000);
      `CHK(q, {8'h00, npulse})
      complete_run();
   end
endmodule

// ===== dv/tpc_pin_model.sv
/* model of the gate/clock pin source: a gate level or a burst of pulses.
   assumes pulses slower than the two-flop synchroniser needs. */
`timescale 1ns/1ns
module tpc_pin_model (
   input  wire logic       gate_i,
   input  wire logic       go_i,
   input  wire logic [7:0] pulses_i,
   output logic            pin_o
);
   logic burst = 1'b0;
   // the line rests low between bursts, so no stray edges are counted
   always @(posedge go_i) begin
      // the 3 ns offset keeps every burst edge clear of a clock edge
      #3;
      repeat (pulses_i) begin
         #20 burst = 1'b1;
         #20 burst = 1'b0;
      end
   end
   assign pin_o = gate_i | burst;
endmodule

// ===== dv/tpc_timer_props.sv
/* port checks for the paired timer, bound into tpc_timer.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ns
module tpc_timer_props (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        gate_clock_input_pin_i,
   input wire logic        cpu_sleep_i,
   input wire logic        cpu_idle_i,
   input wire logic        irq_o,
   input wire logic        adc_trigger_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire req = wb_cyc_i & wb_stb_i;
   // write that turns both enable bits off
   wire en_off = req & wb_we_i & wb_sel_i[0] & (wb_adr_i[11:2] == tpc_pkg::IDX_IRQ_EN)
      & (wb_dat_i[7:6] == 2'b00);
   chk_ack_latency: assert property (req && !wb_ack_o |=> wb_ack_o)
      else $error("request not acked");
   chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_ack_needs_req: assert property (!req |=> !wb_ack_o)
      else $error("ack without request");
   chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
      else $error("upper read data set");
   chk_reset_quiet: assert property ($fell(rst_i) |-> !wb_ack_o && !irq_o && !adc_trigger_o)
      else $error("outputs active after reset");
   chk_sleep_no_adc: assert property (
      $past(cpu_sleep_i) |-> !adc_trigger_o)
      else $error("trigger while asleep");
   chk_irq_en_clear: assert property (
      en_off && !wb_ack_o |=> ##1 !irq_o)
      else $error("irq with enables off");
endmodule
bind tpc_timer tpc_timer_props i_tpc_timer_props (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .gate_clock_input_pin_i(gate_clock_input_pin_i), .cpu_sleep_i(cpu_sleep_i),
   .cpu_idle_i(cpu_idle_i), .irq_o(irq_o), .adc_trigger_o(adc_trigger_o));

// ===== rtl/tpc_pkg.sv
/*
 * constants, register map and control carrier for the paired timer.
 * assumes a classic wishbone slave with 32-bit data, one register per word.
 */
package tpc_pkg;
   localparam int ADR_W = 12;
   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_LO_CNT   = 10'h106;
   localparam logic [9:0] IDX_HOLD     = 10'h108;
   localparam logic [9:0] IDX_HI_CNT   = 10'h10a;
   localparam logic [9:0] IDX_LO_PR    = 10'h10c;
   localparam logic [9:0] IDX_HI_PR    = 10'h10e;
   localparam logic [9:0] IDX_LO_CTL   = 10'h110;
   localparam logic [9:0] IDX_HI_CTL   = 10'h112;
   localparam logic [9:0] IDX_IRQ_FLAG = 10'h084;
   localparam logic [9:0] IDX_IRQ_EN   = 10'h08c;
   // control fields
   localparam int RUN_BIT  = 15;
   localparam int IDLE_BIT = 13;
   localparam int GATE_BIT = 6;
   localparam int PS_LSB   = 4;
   localparam int JOIN_BIT = 3;
   localparam int CSEL_BIT = 1;
   localparam int IRQ_HI_BIT = 7;
   localparam int IRQ_LO_BIT = 6;
   localparam logic [15:0] LO_CTL_MASK = 16'ha07a;
   localparam logic [15:0] HI_CTL_MASK = 16'ha072;
   localparam logic [15:0] IRQ_MASK    = 16'h00c0;
   // reset values
   localparam logic [15:0] PR_RST  = 16'hffff;
   localparam logic [15:0] CTL_RST = 16'h0000;
   localparam logic [15:0] CNT_RST = 16'h0000;
   // prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
   localparam logic [7:0] PS_TC_1   = 8'h00;
   localparam logic [7:0] PS_TC_8   = 8'h07;
   localparam logic [7:0] PS_TC_64  = 8'h3f;
   localparam logic [7:0] PS_TC_256 = 8'hff;

   typedef struct packed {
      logic       run;
      logic       idle_stop;
      logic       gate;
      logic [1:0] psel;
      logic       join_halves_mode;
      logic       csel;
   } tpc_ctrl_t;

   function automatic tpc_ctrl_t to_ctrl(input logic [15:0] r);
      tpc_ctrl_t c;
      c.run       = r[RUN_BIT];
      c.idle_stop = r[IDLE_BIT];
      c.gate      = r[GATE_BIT];
      c.psel      = r[PS_LSB+1:PS_LSB];
      c.join_halves_mode = r[JOIN_BIT];
      c.csel      = r[CSEL_BIT];
      return c;
   endfunction
endpackage

// ===== rtl/tpc_prescale.sv
/*
 * clock prescaler: passes every 1st, 8th, 64th or 256th input tick.
 * assumes tick_i is a one-cycle enable on clk_i.
 */
`timescale 1ns/1ns
module tpc_prescale (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       clr_i,
   input  wire logic       tick_i,
   input  wire logic [1:0] sel_i,
   output logic            tick_o
);
   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;
   logic [7:0] tc;

   always_comb begin
      case (sel_i)
         2'h0:    tc = tpc_pkg::PS_TC_1;
         2'h1:    tc = tpc_pkg::PS_TC_8;
         2'h2:    tc = tpc_pkg::PS_TC_64;
         default: tc = tpc_pkg::PS_TC_256;
      endcase
      tick_o   = tick_i && (cnt_reg >= tc);
      cnt_next = cnt_reg;
      if (clr_i) begin
         cnt_next = 8'h00;
      end else if (tick_o) begin
         cnt_next = 8'h00;
      end else if (tick_i) begin
         cnt_next = cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= 8'h00;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
endmodule

// ===== rtl/tpc_timer.sv
/*
 * paired 16-bit / joined 32-bit timer with wishbone register access.
 * assumes a classic wishbone master on clk_i and a gate/clock pin
 * asynchronous to clk_i; sleep and idle levels come from clk_i logic.
 */
// What this block does
// - gated mode counts only while gate high
// - 32-bit gating uses low half only
// - gate fall stops count without clearing
// - 32-bit period match pulses adc trigger
// - prescale divides by 1, 8, 64, 256
// - 32-bit mode uses only low prescaler
// - count write, run clear, reset clear prescaler
// - stopped low prescaler ignores clears
// - control writes leave counts unchanged
// - sleep stops all counting
// - 32-bit match or gate fall sets flag
// - interrupt only when enable bit set
// - holding register moves upper word atomically
// - joined mode uses low control only
// - low count read latches upper word
// - 32-bit count wraps to zero after period
`timescale 1ns/1ns
module tpc_timer (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [11:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        gate_clock_input_pin_i,
   input  wire logic        cpu_sleep_i,
   input  wire logic        cpu_idle_i,
   output logic             irq_o,
   output logic             adc_trigger_o
);
   logic [15:0] lo_cnt_reg,  lo_cnt_next;
   logic [15:0] hi_cnt_reg,  hi_cnt_next;
   logic [15:0] hold_reg,    hold_next;
   logic [15:0] lo_pr_reg,   lo_pr_next;
   logic [15:0] hi_pr_reg,   hi_pr_next;
   logic [15:0] lo_ctl_reg,  lo_ctl_next;
   logic [15:0] hi_ctl_reg,  hi_ctl_next;
   logic [15:0] flag_reg,    flag_next;
   logic [15:0] en_reg,      en_next;
   logic        ack_reg,     ack_next;
   logic [31:0] dat_reg,     dat_next;
   logic        irq_reg,     irq_next;
   logic        adc_reg,     adc_next;
   logic        pin_s1_reg,  pin_s2_reg,  pin_d_reg;

   tpc_pkg::tpc_ctrl_t lc;
   tpc_pkg::tpc_ctrl_t hc;
   logic [9:0]  idx;
   logic        wr;
   logic        rd;
   logic [15:0] wdat;
   logic        run_lo;
   logic        run_hi;
   logic        pin_rise;
   logic        pin_fall;
   logic        lo_raw;
   logic        hi_raw;
   logic        gate_fall;
   logic        clr_any;
   logic        lo_ps_clr;
   logic        lo_tick;
   logic        hi_tick;
   logic        match32;
   logic        lo_match;
   logic        hi_match;
   logic [31:0] cnt32;
   logic [31:0] pr32;

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                         input logic [1:0] sel);
      logic [15:0] m;
      m = {{8{sel[1]}}, {8{sel[0]}}};
      return (old & ~m) | (nw & m);
   endfunction

   // pin synchroniser; only the second stage and its delayed copy are read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_s1_reg <= 1'b0;
         pin_s2_reg <= 1'b0;
         pin_d_reg  <= 1'b0;
      end else begin
         pin_s1_reg <= gate_clock_input_pin_i;
         pin_s2_reg <= pin_s1_reg;
         pin_d_reg  <= pin_s2_reg;
      end
   end

   // tick sources and prescaler clears
   always_comb begin
      lc        = tpc_pkg::to_ctrl(lo_ctl_reg);
      hc        = tpc_pkg::to_ctrl(hi_ctl_reg);
      idx       = wb_adr_i[11:2];
      wr        = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;
      rd        = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg;
      wdat      = wb_dat_i[15:0];
      pin_rise  = pin_s2_reg && !pin_d_reg;
      pin_fall  = !pin_s2_reg && pin_d_reg;
      run_lo    = lc.run && !cpu_sleep_i && !(cpu_idle_i && lc.idle_stop);
      run_hi    = hc.run && !cpu_sleep_i && !(cpu_idle_i && hc.idle_stop);
      if (lc.csel) begin
         lo_raw = run_lo && pin_rise;
      end else begin
         lo_raw = run_lo && (!lc.gate || pin_s2_reg);
      end
      // the high half has no pin, so its pin modes simply never tick
      hi_raw    = run_hi && !hc.csel && !hc.gate && !lc.join_halves_mode;
      gate_fall = run_lo && !lc.csel && lc.gate && pin_fall;
      clr_any   = (wr && (idx == tpc_pkg::IDX_LO_CNT || idx == tpc_pkg::IDX_HI_CNT))
               || (wr && idx == tpc_pkg::IDX_LO_CTL && wb_sel_i[1] && lc.run
                   && !wdat[tpc_pkg::RUN_BIT])
               || (wr && idx == tpc_pkg::IDX_HI_CTL && wb_sel_i[1] && hc.run
                   && !wdat[tpc_pkg::RUN_BIT]);
      lo_ps_clr = clr_any && lc.run;
   end

   tpc_prescale u_lo_ps (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .clr_i  (lo_ps_clr),
      .tick_i (lo_raw),
      .sel_i  (lc.psel),
      .tick_o (lo_tick)
   );

   tpc_prescale u_hi_ps (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .clr_i  (clr_any),
      .tick_i (hi_raw),
      .sel_i  (hc.psel),
      .tick_o (hi_tick)
   );

   // counting, register writes, flags and bus answer
   always_comb begin
      cnt32       = {hi_cnt_reg, lo_cnt_reg};
      pr32        = {hi_pr_reg, lo_pr_reg};
      match32     = 1'b0;
      lo_match    = 1'b0;
      hi_match    = 1'b0;
      lo_cnt_next = lo_cnt_reg;
      hi_cnt_next = hi_cnt_reg;
      hold_next   = hold_reg;
      lo_pr_next  = lo_pr_reg;
      hi_pr_next  = hi_pr_reg;
      lo_ctl_next = lo_ctl_reg;
      hi_ctl_next = hi_ctl_reg;
      flag_next   = flag_reg;
      en_next     = en_reg;
      dat_next    = 32'h0000_0000;
      ack_next    = wb_cyc_i && wb_stb_i && !ack_reg;
      if (lc.join_halves_mode) begin
         if (lo_tick) begin
            if (cnt32 == pr32) begin
               match32 = 1'b1;
               {hi_cnt_next, lo_cnt_next} = 32'h0000_0000;
            end else begin
               {hi_cnt_next, lo_cnt_next} = cnt32 + 32'h0000_0001;
            end
         end
      end else begin
         if (lo_tick) begin
            if (lo_cnt_reg == lo_pr_reg) begin
               lo_match    = 1'b1;
               lo_cnt_next = tpc_pkg::CNT_RST;
            end else begin
               lo_cnt_next = lo_cnt_reg + 16'h0001;
            end
         end
         if (hi_tick) begin
            if (hi_cnt_reg == hi_pr_reg) begin
               hi_match    = 1'b1;
               hi_cnt_next = tpc_pkg::CNT_RST;
            end else begin
               hi_cnt_next = hi_cnt_reg + 16'h0001;
            end
         end
      end
      // software writes take precedence over a count step in the same cycle
      if (wr) begin
         if (idx == tpc_pkg::IDX_LO_CNT) begin
            lo_cnt_next = merge(lo_cnt_reg, wdat, wb_sel_i[1:0]);
            if (lc.join_halves_mode) begin
               hi_cnt_next = hold_reg;
            end
         end else if (idx == tpc_pkg::IDX_HOLD) begin
            hold_next = merge(hold_reg, wdat, wb_sel_i[1:0]);
         end else if (idx == tpc_pkg::IDX_HI_CNT) begin
            hi_cnt_next = merge(hi_cnt_reg, wdat, wb_sel_i[1:0]);
         end else if (idx == tpc_pkg::IDX_LO_PR) begin
            lo_pr_next = merge(lo_pr_reg, wdat, wb_sel_i[1:0]);
         end else if (idx == tpc_pkg::IDX_HI_PR) begin
            hi_pr_next = merge(hi_pr_reg, wdat, wb_sel_i[1:0]);
         end else if (idx == tpc_pkg::IDX_LO_CTL) begin
            // counts are untouched here
            lo_ctl_next = merge(lo_ctl_reg, wdat, wb_sel_i[1:0])
                        & tpc_pkg::LO_CTL_MASK;
         end else if (idx == tpc_pkg::IDX_HI_CTL) begin
            hi_ctl_next = merge(hi_ctl_reg, wdat, wb_sel_i[1:0])
                        & tpc_pkg::HI_CTL_MASK;
         end else if (idx == tpc_pkg::IDX_IRQ_FLAG) begin
            // writing zero clears a flag, writing one leaves it
            flag_next = flag_reg & (merge(16'hffff, wdat, wb_sel_i[1:0]));
         end else if (idx == tpc_pkg::IDX_IRQ_EN) begin
            en_next = merge(en_reg, wdat, wb_sel_i[1:0]) & tpc_pkg::IRQ_MASK;
         end
      end
      if (rd) begin
         if (idx == tpc_pkg::IDX_LO_CNT) begin
            dat_next[15:0] = lo_cnt_reg;
            if (lc.join_halves_mode) begin
               hold_next = hi_cnt_reg;
            end
         end else if (idx == tpc_pkg::IDX_HOLD) begin
            dat_next[15:0] = hold_reg;
         end else if (idx == tpc_pkg::IDX_HI_CNT) begin
            dat_next[15:0] = hi_cnt_reg;
         end else if (idx == tpc_pkg::IDX_LO_PR) begin
            dat_next[15:0] = lo_pr_reg;
         end else if (idx == tpc_pkg::IDX_HI_PR) begin
            dat_next[15:0] = hi_pr_reg;
         end else if (idx == tpc_pkg::IDX_LO_CTL) begin
            dat_next[15:0] = lo_ctl_reg;
         end else if (idx == tpc_pkg::IDX_HI_CTL) begin
            dat_next[15:0] = hi_ctl_reg;
         end else if (idx == tpc_pkg::IDX_IRQ_FLAG) begin
            dat_next[15:0] = flag_reg;
         end else if (idx == tpc_pkg::IDX_IRQ_EN) begin
            dat_next[15:0] = en_reg;
         end
      end
      // set wins over a software clear in the same cycle
      if (lc.join_halves_mode) begin
         flag_next[tpc_pkg::IRQ_HI_BIT] = flag_next[tpc_pkg::IRQ_HI_BIT]
                                        | match32 | gate_fall;
      end else begin
         flag_next[tpc_pkg::IRQ_LO_BIT] = flag_next[tpc_pkg::IRQ_LO_BIT]
                                        | lo_match | gate_fall;
         flag_next[tpc_pkg::IRQ_HI_BIT] = flag_next[tpc_pkg::IRQ_HI_BIT] | hi_match;
      end
      irq_next = |(flag_next & en_next);
      adc_next = match32 || hi_match;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lo_cnt_reg <= tpc_pkg::CNT_RST;
         hi_cnt_reg <= tpc_pkg::CNT_RST;
         hold_reg   <= tpc_pkg::CNT_RST;
         lo_pr_reg  <= tpc_pkg::PR_RST;
         hi_pr_reg  <= tpc_pkg::PR_RST;
         lo_ctl_reg <= tpc_pkg::CTL_RST;
         hi_ctl_reg <= tpc_pkg::CTL_RST;
         flag_reg   <= 16'h0000;
         en_reg     <= 16'h0000;
         ack_reg    <= 1'b0;
         dat_reg    <= 32'h0000_0000;
         irq_reg    <= 1'b0;
         adc_reg    <= 1'b0;
      end else begin
         lo_cnt_reg <= lo_cnt_next;
         hi_cnt_reg <= hi_cnt_next;
         hold_reg   <= hold_next;
         lo_pr_reg  <= lo_pr_next;
         hi_pr_reg  <= hi_pr_next;
         lo_ctl_reg <= lo_ctl_next;
         hi_ctl_reg <= hi_ctl_next;
         flag_reg   <= flag_next;
         en_reg     <= en_next;
         ack_reg    <= ack_next;
         dat_reg    <= dat_next;
         irq_reg    <= irq_next;
         adc_reg    <= adc_next;
      end
   end

   assign wb_ack_o      = ack_reg;
   assign wb_dat_o      = dat_reg;
   assign irq_o         = irq_reg;
   assign adc_trigger_o = adc_reg;
endmodule
